// ---- logic/omsc_defs.vh ----
`ifndef OMSC_DEFS_VH
`define OMSC_DEFS_VH

// Register addresses, 20-bit, as seen on the register port
`define OMSC_ADDR_W            20
`define OMSC_MODE_IND_ADDR     20'hEE011
`define OMSC_SYS_CTL_ADDR      20'hEE012

// Mode indicator fixed bits
`define OMSC_MODE_IND_FIXED    5'h18

// System control layout and reset value
`define OMSC_SYS_CTL_RESET     8'h09
`define OMSC_SC_STANDBY_SEL    7
`define OMSC_SC_WAIT_HI        6
`define OMSC_SC_WAIT_LO        4
`define OMSC_SC_USER_EN        3
`define OMSC_SC_NMI_EDGE       2
`define OMSC_SC_STBY_OE        1
`define OMSC_SC_RAM_EN         0

// Address space codes
`define OMSC_SPACE_64K         2'h0
`define OMSC_SPACE_1M          2'h1
`define OMSC_SPACE_16M         2'h2

// Access kinds
`define OMSC_ACC_MEM           2'h0
`define OMSC_ACC_PERIPH        2'h1
`define OMSC_ACC_EXT           2'h2

// Access lengths in states
`define OMSC_STATES_SHORT      2'h2
`define OMSC_STATES_LONG       2'h3

// Oscillator settling waits in states, one per wait code
`define OMSC_WAIT_W            19
`define OMSC_WAIT_C0           19'h02000
`define OMSC_WAIT_C1           19'h04000
`define OMSC_WAIT_C2           19'h08000
`define OMSC_WAIT_C3           19'h10000
`define OMSC_WAIT_C4           19'h20000
`define OMSC_WAIT_C5           19'h40000
`define OMSC_WAIT_C6           19'h00400

`endif

// ---- logic/omsc_acc_seq.v ----
`timescale 1ns/1ps
`default_nettype none
`include "omsc_defs.vh"

module omsc_acc_seq (
  input  wire       sys_clk,   // System clock
  input  wire       srst,      // Sync reset, high
  input  wire       start,     // Begin an access cycle
  input  wire       long_cyc,  // 1: three states, 0: two states
  output reg        busy_reg,  // Cycle in progress
  output reg        done_reg   // Last state of the cycle
);

  reg  [1:0] count_reg;
  reg  [1:0] last_reg;
  wire [1:0] last_next;

  assign last_next = long_cyc ? `OMSC_STATES_LONG : `OMSC_STATES_SHORT; // R17

  always @(posedge sys_clk) begin
    if (srst) begin
      count_reg <= 2'h0;
      last_reg  <= 2'h0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end else if (!busy_reg) begin
      done_reg <= 1'b0;
      if (start) begin
        busy_reg  <= 1'b1;
        count_reg <= 2'h1;
        last_reg  <= last_next;
        done_reg  <= (last_next == 2'h1);
      end
    end else begin
      // One state per rising edge
      count_reg <= count_reg + 2'h1; // R17
      if (count_reg + 2'h1 == last_reg) begin
        done_reg <= 1'b1;
      end else if (count_reg == last_reg) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b0;
      end
    end
  end

endmodule // omsc_acc_seq

`default_nettype wire

// ---- logic/omsc_top.v ----
// Function
// R01: On-chip memory: two states, 16-bit, byte/word
// R02: Peripheral register: three states, 8/16 bits
// R03: Eight external areas, per-area width and states
// R04: Mode pins 1-7 select modes; zero prohibited
// R05: Modes set external, ROM and initial width
// R06: External bus 8-bit only if all areas 8-bit
// R07: Address space per mode: 1M, 16M, 64K
// R08: Single-chip modes internal only; RAM-off goes external
// R09: System keeps mode pins steady, valid, reset-changed
// R10: Mode indicator read-only, top ones, middle zeros
// R11: Low bits show mode pins, latched on read
// R12: Flash boot inverts top mode bit
// R13: Standby select picks sleep or software standby
// R14: Standby select stays set after wake
// R15: Wait code picks settling states; 111 illegal
// R16: Software sets wait at least seven milliseconds
// R17: State is clock period; cycles two or three
// R18: User enable: mask flag or user bit
// R19: Non-maskable edge select: falling or rising
// R20: Standby output enable: float or hold outputs
// R21: RAM enable resets to one, kept in standby
// R22: Writes to mode indicator are ignored
`timescale 1ns/1ps
`default_nettype none
`include "omsc_defs.vh"

module omsc_top #(
  parameter [18:0] WAIT_S0 = `OMSC_WAIT_C0, // Settling states, code 000
  parameter [18:0] WAIT_S1 = `OMSC_WAIT_C1, // Code 001
  parameter [18:0] WAIT_S2 = `OMSC_WAIT_C2, // Code 010
  parameter [18:0] WAIT_S3 = `OMSC_WAIT_C3, // Code 011
  parameter [18:0] WAIT_S4 = `OMSC_WAIT_C4, // Code 100
  parameter [18:0] WAIT_S5 = `OMSC_WAIT_C5, // Code 101
  parameter [18:0] WAIT_S6 = `OMSC_WAIT_C6, // Code 110
  parameter        AREAS   = 8              // External areas
) (
  input  wire                    sys_clk,          // System clock, 200 MHz
  input  wire                    srst,             // Sync reset, high
  input  wire [19:0]             reg_addr,         // Register address
  input  wire [7:0]              reg_wdata,        // Write data
  input  wire                    reg_wr,           // Write strobe
  input  wire                    reg_rd,           // Read strobe
  output reg  [7:0]              reg_rdata_reg,    // Read data, cycle after strobe
  input  wire [2:0]              mode_pins,        // Mode pin levels
  input  wire                    flash_boot,       // Flash boot mode active
  input  wire [AREAS-1:0]        area_width_16,    // Per-area 16-bit select
  input  wire [AREAS-1:0]        area_long,        // Per-area three-state select
  input  wire                    sleep_exec,       // Sleep instruction executed
  input  wire                    wake_irq,         // Any interrupt, ends sleep
  input  wire                    ext_wake,         // External interrupt, ends standby
  input  wire                    nmi_pin,          // Non-maskable interrupt input
  input  wire                    acc_req,          // Access request
  input  wire [1:0]              acc_kind,         // Memory, peripheral, external
  input  wire [2:0]              acc_area,         // External area number
  input  wire                    acc_reg16,        // Peripheral register is 16-bit
  input  wire                    acc_word,         // Word transfer requested
  output reg  [2:0]              mode_num_reg,     // Current mode, 0 when invalid
  output reg                     mode_valid_reg,   // Mode pins select 1 to 7
  output reg  [1:0]              addr_space_reg,   // Address space code
  output reg                     ext_enable_reg,   // External access allowed
  output reg                     rom_enable_reg,   // On-chip ROM enabled
  output reg                     ram_enable_reg,   // On-chip RAM enabled
  output reg                     ram_to_ext_reg,   // RAM range is external
  output reg                     init_bus16_reg,   // Initial external width 16
  output reg                     ext_bus16_reg,    // External bus runs 16-bit
  output reg                     sleep_active_reg, // In sleep mode
  output reg                     standby_reg,      // In software standby
  output reg                     settling_reg,     // Oscillator settling wait
  output reg                     user_mask_reg,    // User flag acts as mask
  output reg                     nmi_req_reg,      // Non-maskable request pulse
  output reg                     addr_oe_reg,      // Address bus output enable
  output reg                     ctl_oe_reg,       // Bus control output enable
  output reg                     ctl_high_reg,     // Bus control forced high
  output reg                     addr_hold_reg,    // Address retained
  output reg                     acc_busy_reg,     // Access cycle running
  output wire                    acc_done,         // Last state of access
  output reg                     acc_wide_reg,     // Access uses 16-bit path
  output reg                     acc_split_reg     // Word over 8-bit path
);

  localparam [3:0] ST_RUN    = 4'h1;
  localparam [3:0] ST_SLEEP  = 4'h2;
  localparam [3:0] ST_STBY   = 4'h4;
  localparam [3:0] ST_SETTLE = 4'h8;

  reg  [7:0]  sys_ctl_reg;
  reg  [7:0]  sys_ctl_next;
  reg  [3:0]  pwr_reg;
  reg  [3:0]  pwr_next;
  reg  [18:0] wait_cnt_reg;
  reg  [18:0] wait_cnt_next;
  reg  [18:0] wait_load;
  reg         nmi_prev_reg;
  reg  [2:0]  mode_next;
  reg  [1:0]  space_next;
  reg         ext_next;
  reg         rom_next;
  reg         init16_next;
  reg         acc_long;
  reg         acc_wide_next;
  reg  [7:0]  rdata_next;
  wire [2:0]  mode_bits;
  wire        expanded;
  wire        sel_mode;
  wire        sel_sys;
  wire        seq_busy;
  wire        area16;
  wire        arealong;
  wire        acc_start;

  assign sel_mode = (reg_addr == `OMSC_MODE_IND_ADDR);
  assign sel_sys  = (reg_addr == `OMSC_SYS_CTL_ADDR);

  // Live pin levels, top bit flipped in flash boot
  assign mode_bits = {mode_pins[2] ^ flash_boot, mode_pins[1:0]}; // R12

  assign expanded  = (mode_pins != 3'h0) && (mode_pins <= 3'h5);
  assign area16    = area_width_16[acc_area];
  assign arealong  = area_long[acc_area];
  assign acc_start = acc_req && !seq_busy;

  // Mode decode
  always @* begin
    mode_next   = mode_pins; // R04
    space_next  = `OMSC_SPACE_1M;
    ext_next    = 1'b0;
    rom_next    = 1'b0;
    init16_next = 1'b0;
    case (mode_pins)
      3'h1: begin
        ext_next = 1'b1; // R05
      end
      3'h2: begin
        ext_next    = 1'b1; // R05
        init16_next = 1'b1;
      end
      3'h3: begin
        ext_next   = 1'b1; // R05
        space_next = `OMSC_SPACE_16M; // R07
      end
      3'h4: begin
        ext_next    = 1'b1; // R05
        init16_next = 1'b1;
        space_next  = `OMSC_SPACE_16M; // R07
      end
      3'h5: begin
        ext_next   = 1'b1; // R05
        rom_next   = 1'b1;
        space_next = `OMSC_SPACE_16M; // R07
      end
      3'h6: begin
        rom_next   = 1'b1; // R08
        space_next = `OMSC_SPACE_64K; // R07
      end
      3'h7: begin
        rom_next = 1'b1; // R08
      end
      default: begin
        // Prohibited setting: nothing enabled
        mode_next = 3'h0; // R04
      end
    endcase
  end

  // Settling wait per code
  always @* begin
    case (sys_ctl_reg[`OMSC_SC_WAIT_HI:`OMSC_SC_WAIT_LO])
      3'h0:    wait_load = WAIT_S0; // R15
      3'h1:    wait_load = WAIT_S1;
      3'h2:    wait_load = WAIT_S2;
      3'h3:    wait_load = WAIT_S3;
      3'h4:    wait_load = WAIT_S4;
      3'h5:    wait_load = WAIT_S5;
      3'h6:    wait_load = WAIT_S6;
      default: wait_load = WAIT_S5; // Illegal code, longest wait
    endcase
  end

  // System control writes; the mode indicator has no write path
  always @* begin
    sys_ctl_next = sys_ctl_reg;
    if (reg_wr && sel_sys) begin
      sys_ctl_next = reg_wdata; // R13
    end
    // Standby select is never cleared by hardware on wake
  end

  // Power state machine
  always @* begin
    pwr_next      = pwr_reg;
    wait_cnt_next = wait_cnt_reg;
    case (pwr_reg)
      ST_RUN: begin
        if (sleep_exec) begin
          if (sys_ctl_reg[`OMSC_SC_STANDBY_SEL]) begin
            pwr_next = ST_STBY; // R13
          end else begin
            pwr_next = ST_SLEEP; // R13
          end
        end
      end
      ST_SLEEP: begin
        if (wake_irq) begin
          pwr_next = ST_RUN;
        end
      end
      ST_STBY: begin
        if (ext_wake) begin
          pwr_next      = ST_SETTLE;
          wait_cnt_next = wait_load; // R15
        end
      end
      ST_SETTLE: begin
        wait_cnt_next = wait_cnt_reg - 19'h00001;
        if (wait_cnt_reg <= 19'h00001) begin
          pwr_next      = ST_RUN; // R14
          wait_cnt_next = 19'h00000;
        end
      end
      default: begin
        pwr_next = ST_RUN;
      end
    endcase
  end

  // Read data mux, pins sampled at the read
  always @* begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      if (sel_mode) begin
        rdata_next = {`OMSC_MODE_IND_FIXED, mode_bits}; // R10 R11
      end else if (sel_sys) begin
        rdata_next = sys_ctl_reg;
      end
    end
  end

  // Access path selection
  always @* begin
    case (acc_kind)
      `OMSC_ACC_MEM: begin
        acc_long      = 1'b0; // R01
        acc_wide_next = 1'b1; // R01
      end
      `OMSC_ACC_PERIPH: begin
        acc_long      = 1'b1; // R02
        acc_wide_next = acc_reg16; // R02
      end
      default: begin
        acc_long      = arealong; // R03
        acc_wide_next = area16; // R03
      end
    endcase
  end

  omsc_acc_seq omsc_acc_seq_inst (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .start    (acc_start),
    .long_cyc (acc_long),
    .busy_reg (seq_busy),
    .done_reg (acc_done)
  );

  always @(posedge sys_clk) begin
    if (srst) begin
      sys_ctl_reg      <= `OMSC_SYS_CTL_RESET; // R21
      pwr_reg          <= ST_RUN;
      wait_cnt_reg     <= 19'h00000;
      nmi_prev_reg     <= 1'b0;
      reg_rdata_reg    <= 8'h00;
      mode_num_reg     <= 3'h0;
      mode_valid_reg   <= 1'b0;
      addr_space_reg   <= `OMSC_SPACE_1M;
      ext_enable_reg   <= 1'b0;
      rom_enable_reg   <= 1'b0;
      ram_enable_reg   <= 1'b1;
      ram_to_ext_reg   <= 1'b0;
      init_bus16_reg   <= 1'b0;
      ext_bus16_reg    <= 1'b0;
      sleep_active_reg <= 1'b0;
      standby_reg      <= 1'b0;
      settling_reg     <= 1'b0;
      user_mask_reg    <= 1'b0;
      nmi_req_reg      <= 1'b0;
      addr_oe_reg      <= 1'b0;
      ctl_oe_reg       <= 1'b0;
      ctl_high_reg     <= 1'b0;
      addr_hold_reg    <= 1'b0;
      acc_busy_reg     <= 1'b0;
      acc_wide_reg     <= 1'b0;
      acc_split_reg    <= 1'b0;
    end else begin
      sys_ctl_reg    <= sys_ctl_next; // R22
      pwr_reg        <= pwr_next;
      wait_cnt_reg   <= wait_cnt_next;
      nmi_prev_reg   <= nmi_pin;
      reg_rdata_reg  <= rdata_next;
      mode_num_reg   <= mode_next; // R04
      mode_valid_reg <= (mode_pins != 3'h0); // R04
      addr_space_reg <= space_next; // R07
      ext_enable_reg <= ext_next; // R05
      rom_enable_reg <= rom_next; // R05
      ram_enable_reg <= sys_ctl_reg[`OMSC_SC_RAM_EN]; // R21
      ram_to_ext_reg <= expanded && !sys_ctl_reg[`OMSC_SC_RAM_EN]; // R08
      init_bus16_reg <= init16_next; // R05
      ext_bus16_reg  <= expanded && (|area_width_16); // R06
      sleep_active_reg <= (pwr_next == ST_SLEEP);
      standby_reg      <= (pwr_next == ST_STBY);
      settling_reg     <= (pwr_next == ST_SETTLE);
      user_mask_reg    <= !sys_ctl_reg[`OMSC_SC_USER_EN]; // R18
      if (sys_ctl_reg[`OMSC_SC_NMI_EDGE]) begin
        nmi_req_reg <= nmi_pin && !nmi_prev_reg; // R19
      end else begin
        nmi_req_reg <= !nmi_pin && nmi_prev_reg; // R19
      end
      if (pwr_next == ST_STBY) begin
        addr_oe_reg   <= ext_next && sys_ctl_reg[`OMSC_SC_STBY_OE]; // R20
        ctl_oe_reg    <= ext_next && sys_ctl_reg[`OMSC_SC_STBY_OE]; // R20
        ctl_high_reg  <= sys_ctl_reg[`OMSC_SC_STBY_OE]; // R20
        addr_hold_reg <= sys_ctl_reg[`OMSC_SC_STBY_OE]; // R20
      end else begin
        addr_oe_reg   <= ext_next; // R08
        ctl_oe_reg    <= ext_next;
        ctl_high_reg  <= 1'b0;
        addr_hold_reg <= 1'b0;
      end
      if (acc_start) begin
        acc_busy_reg  <= 1'b1;
        acc_wide_reg  <= acc_wide_next; // R01 R02 R03
        acc_split_reg <= acc_word && !acc_wide_next;
      end else if (acc_done) begin
        acc_busy_reg <= 1'b0;
      end
    end
  end

endmodule // omsc_top

`default_nettype wire

// ---- test/omsc_ctl_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "omsc_defs.vh"

module omsc_ctl_monitor #(
  parameter AREAS = 8
) (
  input wire logic             sys_clk,        // Clock
  input wire logic             srst,           // Reset
  input wire logic [19:0]      reg_addr,       // Address
  input wire logic             reg_rd,         // Read strobe
  input wire logic [7:0]       reg_rdata_reg,  // Read data
  input wire logic [2:0]       mode_pins,      // Mode pins
  input wire logic             flash_boot,     // Boot mode
  input wire logic [AREAS-1:0] area_long,      // Three-state areas
  input wire logic             acc_req,        // Access request
  input wire logic [1:0]       acc_kind,       // Access kind
  input wire logic [2:0]       acc_area,       // Area number
  input wire logic             acc_busy_reg,   // Busy
  input wire logic             acc_done,       // Done pulse
  input wire logic [2:0]       mode_num_reg,   // Mode
  input wire logic             mode_valid_reg, // Mode valid
  input wire logic [1:0]       addr_space_reg, // Space code
  input wire logic             rom_enable_reg, // ROM on
  input wire logic             ext_enable_reg  // External on
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  wire mi = reg_rd && reg_addr == `OMSC_MODE_IND_ADDR;
  wire tk = acc_req && !acc_busy_reg;

  rd_fixed_a: assert property (mi |=> reg_rdata_reg[7:3] == 5'h18)
    else $error("mode indicator fixed bits wrong");
  rd_pins_a: assert property (mi && !flash_boot |=> reg_rdata_reg[2:0] == $past(mode_pins))
    else $error("mode indicator low bits differ from pins");
  boot_inv_a: assert property (mi && flash_boot |=> reg_rdata_reg[2] == !$past(mode_pins[2]))
    else $error("boot mode top bit not inverted");
  mode_track_a: assert property (!$past(srst) |-> mode_num_reg == $past(mode_pins) &&
    mode_valid_reg == ($past(mode_pins) != 3'h0))
    else $error("mode number does not follow pins");
  mode_map_a: assert property (mode_valid_reg |-> rom_enable_reg == (mode_num_reg >= 3'h5) &&
    ext_enable_reg == (mode_num_reg <= 3'h5))
    else $error("ROM or external enable wrong for mode");
  space_map_a: assert property (mode_valid_reg |-> addr_space_reg == (mode_num_reg == 3'h6 ?
    2'h0 : (mode_num_reg >= 3'h3 && mode_num_reg <= 3'h5) ? 2'h2 : 2'h1))
    else $error("address space wrong for mode");
  mem_two_a: assert property (tk && acc_kind == 2'h0 |=> !acc_done ##1 acc_done)
    else $error("memory access not two states");
  periph_three_a: assert property (tk && acc_kind == 2'h1 |=> !acc_done [*2] ##1 acc_done)
    else $error("peripheral access not three states");
  ext_short_a: assert property (tk && acc_kind[1] && !area_long[acc_area] |=> !acc_done
    ##1 acc_done)
    else $error("short external access length wrong");
  ext_long_a: assert property (tk && acc_kind[1] && area_long[acc_area] |=> !acc_done [*2]
    ##1 acc_done)
    else $error("long external access length wrong");
endmodule // omsc_ctl_monitor

bind omsc_top omsc_ctl_monitor #(.AREAS(AREAS)) omsc_ctl_monitor_inst (
  .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata_reg(reg_rdata_reg), .mode_pins(mode_pins), .flash_boot(flash_boot),
  .area_long(area_long), .acc_req(acc_req), .acc_kind(acc_kind), .acc_area(acc_area),
  .acc_busy_reg(acc_busy_reg), .acc_done(acc_done), .mode_num_reg(mode_num_reg),
  .mode_valid_reg(mode_valid_reg), .addr_space_reg(addr_space_reg),
  .rom_enable_reg(rom_enable_reg), .ext_enable_reg(ext_enable_reg));
`default_nettype wire

// ---- test/omsc_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module omsc_top_tb;
  // Shortened settling waits; code 7 falls back to the longest
  localparam logic [18:0] WT [0:7] = '{19'h10, 19'h12, 19'h14, 19'h16,
                                       19'h18, 19'h1A, 19'h0C, 19'h1A};
  logic sys_clk, srst, reg_wr, reg_rd, flash_boot, sleep_exec, wake_irq, ext_wake;
  logic nmi_pin, acc_req, acc_reg16, acc_word, acc_done, seen;
  logic [19:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata_reg, area_width_16, area_long;
  logic [2:0]  mode_pins, acc_area, mode_num_reg;
  logic [1:0]  acc_kind, addr_space_reg;
  logic mode_valid_reg, ext_enable_reg, rom_enable_reg, ram_enable_reg, ram_to_ext_reg;
  logic init_bus16_reg, ext_bus16_reg, sleep_active_reg, standby_reg, settling_reg;
  logic user_mask_reg, nmi_req_reg, addr_oe_reg, ctl_oe_reg, ctl_high_reg, addr_hold_reg;
  logic acc_busy_reg, acc_wide_reg, acc_split_reg;
  int n_mismatch, compares, cyc, n;

  omsc_top #(.WAIT_S0(WT[0]), .WAIT_S1(WT[1]), .WAIT_S2(WT[2]), .WAIT_S3(WT[3]),
    .WAIT_S4(WT[4]), .WAIT_S5(WT[5]), .WAIT_S6(WT[6])) omsc_top_inst (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg), .mode_pins(mode_pins),
    .flash_boot(flash_boot), .area_width_16(area_width_16), .area_long(area_long),
    .sleep_exec(sleep_exec), .wake_irq(wake_irq), .ext_wake(ext_wake), .nmi_pin(nmi_pin),
    .acc_req(acc_req), .acc_kind(acc_kind), .acc_area(acc_area), .acc_reg16(acc_reg16),
    .acc_word(acc_word), .mode_num_reg(mode_num_reg), .mode_valid_reg(mode_valid_reg),
    .addr_space_reg(addr_space_reg), .ext_enable_reg(ext_enable_reg),
    .rom_enable_reg(rom_enable_reg), .ram_enable_reg(ram_enable_reg),
    .ram_to_ext_reg(ram_to_ext_reg), .init_bus16_reg(init_bus16_reg),
    .ext_bus16_reg(ext_bus16_reg), .sleep_active_reg(sleep_active_reg),
    .standby_reg(standby_reg), .settling_reg(settling_reg), .user_mask_reg(user_mask_reg),
    .nmi_req_reg(nmi_req_reg), .addr_oe_reg(addr_oe_reg), .ctl_oe_reg(ctl_oe_reg),
    .ctl_high_reg(ctl_high_reg), .addr_hold_reg(addr_hold_reg), .acc_busy_reg(acc_busy_reg),
    .acc_done(acc_done), .acc_wide_reg(acc_wide_reg), .acc_split_reg(acc_split_reg));

  always #2.5 sys_clk = ~sys_clk;

  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [19:0] a, input logic [7:0] e, input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata_reg);
  endtask

  task automatic rst(input logic [2:0] m);
    srst <= 1'b1;
    mode_pins <= m;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic acc(input logic [1:0] k, input logic lg, input logic wd, input int st,
                     input logic ew, input logic es);
    @(posedge sys_clk);
    acc_req <= 1'b1;
    acc_kind <= k;
    area_long <= {8{lg}};
    acc_word <= wd;
    @(posedge sys_clk);
    acc_req <= 1'b0;
    n = 1;
    #1;
    while (acc_done !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("states", st, n);
    chk("busy", 1, acc_busy_reg);
    chk("wide", ew, acc_wide_reg);
    chk("split", es, acc_split_reg);
  endtask

  task automatic nmi(input logic v, input logic e);
    @(posedge sys_clk);
    nmi_pin <= v;
    seen = 1'b0;
    repeat (4) begin
      @(posedge sys_clk);
      #1 seen = seen | nmi_req_reg;
    end
    chk("nmi", e, seen);
  endtask

  // Pulse 0: sleep instruction, 1: wake interrupt, 2: external wake
  task automatic pulse(input int w);
    @(posedge sys_clk);
    sleep_exec <= (w == 0);
    wake_irq <= (w == 1);
    ext_wake <= (w == 2);
    @(posedge sys_clk);
    {sleep_exec, wake_irq, ext_wake} <= 3'h0;
    #1;
  endtask

  initial begin
    {sys_clk, srst, reg_wr, reg_rd, flash_boot, sleep_exec, wake_irq, ext_wake} = 8'h40;
    {acc_req, acc_reg16, acc_word, nmi_pin} = 4'h1;
    {reg_addr, reg_wdata, area_width_16, area_long} = 44'h0;
    {mode_pins, acc_area, acc_kind} = 8'h10;
    for (int m = 0; m < 8; m++) begin
      rst(m[2:0]);
      chk("valid", m != 0, mode_valid_reg);
      if (m != 0) begin
        chk("init16", m <= 5 && m % 2 == 0, init_bus16_reg);
        rd(20'hEE011, {5'h18, m[2:0]}, "mode_indicator_reg");
        wr(20'hEE011, 8'h00);
        rd(20'hEE011, {5'h18, m[2:0]}, "mode_indicator_reg_wr");
        flash_boot <= (m == 5);
        rd(20'hEE011, {5'h18, m[2] ^ (m == 5), m[1:0]}, "boot");
        flash_boot <= 1'b0;
      end
    end
    $display("test modes done");
    rst(3'h1);
    rd(20'hEE012, 8'h09, "sysctl_rst");
    rd(20'hEE013, 8'h00, "unmapped");
    chk("ram_on", 1, ram_enable_reg);
    chk("umask", 0, user_mask_reg);
    wr(20'hEE012, 8'h00);
    rd(20'hEE012, 8'h00, "sysctl_wr");
    chk("umask1", 1, user_mask_reg);
    chk("ram_ext", 1, ram_to_ext_reg);
    chk("bus8", 0, ext_bus16_reg);
    area_width_16 <= 8'h80;
    repeat (2) @(posedge sys_clk);
    #1 chk("bus16", 1, ext_bus16_reg);
    acc(2'h0, 1'b0, 1'b1, 2, 1'b1, 1'b0);
    acc(2'h1, 1'b0, 1'b0, 3, 1'b0, 1'b0);
    acc_reg16 <= 1'b1;
    acc(2'h1, 1'b0, 1'b1, 3, 1'b1, 1'b0);
    acc(2'h2, 1'b0, 1'b1, 2, 1'b0, 1'b1);
    acc_area <= 3'h7;
    acc(2'h2, 1'b0, 1'b1, 2, 1'b1, 1'b0);
    acc_area <= 3'h4;
    acc(2'h3, 1'b1, 1'b0, 3, 1'b0, 1'b0);
    nmi(1'b0, 1'b1);
    nmi(1'b1, 1'b0);
    wr(20'hEE012, 8'h04);
    nmi(1'b0, 1'b0);
    nmi(1'b1, 1'b1);
    $display("test control done");
    pulse(0);
    chk("sleep", 1, sleep_active_reg);
    chk("no_stby", 0, standby_reg);
    pulse(1);
    @(posedge sys_clk);
    #1 chk("woke", 0, sleep_active_reg);
    for (int c = 0; c < 8; c++) begin
      wr(20'hEE012, {1'b1, c[2:0], 2'h0, c[0], 1'b1});
      pulse(0);
      chk("stby", 1, standby_reg);
      @(posedge sys_clk);
      #1 chk("aoe", c[0], addr_oe_reg);
      chk("chigh", c[0], ctl_high_reg);
      chk("coe", c[0], ctl_oe_reg);
      chk("ahold", c[0], addr_hold_reg);
      pulse(2);
      n = 0;
      while (settling_reg === 1'b1 && n < 300) begin
        @(posedge sys_clk);
        #1 n++;
      end
      chk("wait", WT[c], n);
      rd(20'hEE012, {1'b1, c[2:0], 2'h0, c[0], 1'b1}, "standby_select_kept");
    end
    $display("test standby done");
    wrap_up();
  end
endmodule // omsc_top_tb
`default_nettype wire
